//--- rtl/cbrf_top.v
// cbrf_top: banked cpu register set with flags, pc, stack pointers and vector bases
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "cbrf_regs.vh"
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------

module cbrf_top #(
  parameter DW = 16,
  parameter AW = 20,
  parameter FW = 11
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [4:0]    reg_addr,
  input  wire [AW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [AW-1:0] reg_rdata,
  input  wire          long_wr,
  input  wire [1:0]    long_sel,
  input  wire [31:0]   long_wdata,
  input  wire          alu_flag_we,
  input  wire [1:0]    alu_size,
  input  wire [31:0]   alu_result,
  input  wire          alu_carry,
  input  wire          alu_overflow,
  input  wire          pc_adv,
  input  wire [2:0]    pc_step,
  input  wire          vec_req,
  input  wire          vec_fixed,
  input  wire [5:0]    vec_num,
  output reg  [AW-1:0] vec_addr,
  output reg           vec_ack,
  output wire [31:0]   long_data_pair_low,
  output wire [31:0]   long_data_pair_high,
  output wire [31:0]   long_pointer_pair,
  output wire [DW-1:0] frame_base,
  output wire [DW-1:0] static_base,
  output wire [DW-1:0] active_stack_pointer,
  output wire [AW-1:0] program_counter,
  output wire [AW-1:0] vector_table_base,
  output wire [FW-1:0] processor_flags
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [DW-1:0] bank_q [0:13];            // two banks of seven words
  reg  [AW-1:0] vector_table_base_q;
  reg  [AW-1:0] program_counter_q;
  reg  [DW-1:0] user_stack_pointer_q;
  reg  [DW-1:0] interrupt_stack_pointer_q;
  reg  [DW-1:0] static_base_q;
  reg  [FW-1:0] processor_flags_q;
  reg  [FW-1:0] processor_flags_d;
  wire          bank_sel;
  wire          stack_sel;
  integer       i;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // array index of a banked slot in the chosen bank
  function [3:0] bidx;
    input       bank;
    input [2:0] slot;
    begin
      bidx = {1'b0, slot} + (bank ? `CBRF_BANK_SLOTS : 4'h0);
    end
  endfunction

  // register index to banked slot, for the plain banked words
  function [2:0] slot_of;
    input [4:0] idx;
    begin
      slot_of = idx[2:0];
    end
  endfunction

  // true when the index names a whole banked word
  function is_banked;
    input [4:0] idx;
    begin
      is_banked = (idx <= `CBRF_IDX_FB);
    end
  endfunction

  assign bank_sel  = processor_flags_q[`CBRF_FLG_B];
  assign stack_sel = processor_flags_q[`CBRF_FLG_U];

  // ----------------------------------------------------------------------
  // operand views toward the datapath
  // ----------------------------------------------------------------------
  // 32-bit data pairs, words 2 and 3 as upper halves
  assign long_data_pair_low  = {bank_q[bidx(bank_sel, `CBRF_SLOT_DW2)],
                                bank_q[bidx(bank_sel, `CBRF_SLOT_DW0)]};
  assign long_data_pair_high = {bank_q[bidx(bank_sel, `CBRF_SLOT_DW3)],
                                bank_q[bidx(bank_sel, `CBRF_SLOT_DW1)]};
  // 32-bit pointer pair, pointer 1 as upper half
  assign long_pointer_pair   = {bank_q[bidx(bank_sel, `CBRF_SLOT_PW1)],
                                bank_q[bidx(bank_sel, `CBRF_SLOT_PW0)]};
  assign frame_base          = bank_q[bidx(bank_sel, `CBRF_SLOT_FB)];
  assign static_base         = static_base_q;
  // stack flag low selects the interrupt stack
  assign active_stack_pointer = stack_sel ? user_stack_pointer_q
                                          : interrupt_stack_pointer_q;
  assign program_counter     = program_counter_q;
  assign vector_table_base   = vector_table_base_q;
  assign processor_flags     = processor_flags_q;

  // ----------------------------------------------------------------------
  // banked words: long writes first, register port wins on overlap
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      for (i = 0; i < 14; i = i + 1)
        bank_q[i] <= `CBRF_WORD_RST;
    end
    else
    begin
      if (long_wr)
      begin
        case (long_sel)
          `CBRF_LONG_DLO:
          begin
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW0)] <= long_wdata[15:0];
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW2)] <= long_wdata[31:16];
          end
          `CBRF_LONG_DHI:
          begin
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW1)] <= long_wdata[15:0];
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW3)] <= long_wdata[31:16];
          end
          `CBRF_LONG_PTR:
          begin
            bank_q[bidx(bank_sel, `CBRF_SLOT_PW0)] <= long_wdata[15:0];
            bank_q[bidx(bank_sel, `CBRF_SLOT_PW1)] <= long_wdata[31:16];
          end
          default:
          begin
          end
        endcase
      end
      if (reg_wr)
      begin
        if (is_banked(reg_addr))
          bank_q[bidx(bank_sel, slot_of(reg_addr))] <= reg_wdata[15:0];
        case (reg_addr)
          `CBRF_IDX_DW0_UB:
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW0)][15:8] <= reg_wdata[7:0];
          `CBRF_IDX_DW0_LB:
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW0)][7:0]  <= reg_wdata[7:0];
          `CBRF_IDX_DW1_UB:
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW1)][15:8] <= reg_wdata[7:0];
          `CBRF_IDX_DW1_LB:
            bank_q[bidx(bank_sel, `CBRF_SLOT_DW1)][7:0]  <= reg_wdata[7:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // unbanked words
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      vector_table_base_q       <= `CBRF_ADDR_RST;
      program_counter_q         <= `CBRF_ADDR_RST;
      user_stack_pointer_q      <= `CBRF_WORD_RST;
      interrupt_stack_pointer_q <= `CBRF_WORD_RST;
      static_base_q             <= `CBRF_WORD_RST;
    end
    else
    begin
      // pc steps wrap inside the 1 MB space, a port write overrides
      if (reg_wr && reg_addr == `CBRF_IDX_PC)
        program_counter_q <= reg_wdata;
      else if (pc_adv)
        program_counter_q <= program_counter_q + {{(AW-3){1'b0}}, pc_step};
      if (reg_wr)
      begin
        case (reg_addr)
          `CBRF_IDX_VTB: vector_table_base_q       <= reg_wdata;
          `CBRF_IDX_USP: user_stack_pointer_q      <= reg_wdata[15:0];
          `CBRF_IDX_ISP: interrupt_stack_pointer_q <= reg_wdata[15:0];
          `CBRF_IDX_SB:  static_base_q             <= reg_wdata[15:0];
          `CBRF_IDX_ASP:
          begin
            if (stack_sel)
              user_stack_pointer_q      <= reg_wdata[15:0];
            else
              interrupt_stack_pointer_q <= reg_wdata[15:0];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // flags: alu update of c, z, s, o wins over a port write
  // ----------------------------------------------------------------------
  always @*
  begin
    processor_flags_d = processor_flags_q;
    if (reg_wr && reg_addr == `CBRF_IDX_FLG)
      processor_flags_d = reg_wdata[FW-1:0];
    if (alu_flag_we)
    begin
      processor_flags_d[`CBRF_FLG_C] = alu_carry;
      processor_flags_d[`CBRF_FLG_O] = alu_overflow;
      case (alu_size)
        `CBRF_SIZE_BYTE:
        begin
          processor_flags_d[`CBRF_FLG_Z] = (alu_result[7:0] == 8'h00);
          processor_flags_d[`CBRF_FLG_S] = alu_result[7];
        end
        `CBRF_SIZE_LONG:
        begin
          processor_flags_d[`CBRF_FLG_Z] = (alu_result == 32'h00000000);
          processor_flags_d[`CBRF_FLG_S] = alu_result[31];
        end
        default:
        begin
          processor_flags_d[`CBRF_FLG_Z] = (alu_result[15:0] == 16'h0000);
          processor_flags_d[`CBRF_FLG_S] = alu_result[15];
        end
      endcase
    end
  end

  // flag register
  always @(posedge clk)
  begin
    if (rst)
      processor_flags_q <= `CBRF_FLG_RST;
    else
      processor_flags_q <= processor_flags_d;
  end

  // ----------------------------------------------------------------------
  // register port read, data stands one cycle only
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst || !reg_rd)
      reg_rdata <= {AW{1'b0}};
    else
    begin
      case (reg_addr)
        `CBRF_IDX_DW0, `CBRF_IDX_DW1, `CBRF_IDX_DW2, `CBRF_IDX_DW3,
        `CBRF_IDX_PW0, `CBRF_IDX_PW1, `CBRF_IDX_FB:
          reg_rdata <= {4'h0, bank_q[bidx(bank_sel, slot_of(reg_addr))]};
        `CBRF_IDX_VTB: reg_rdata <= vector_table_base_q;
        `CBRF_IDX_PC:  reg_rdata <= program_counter_q;
        `CBRF_IDX_USP: reg_rdata <= {4'h0, user_stack_pointer_q};
        `CBRF_IDX_ISP: reg_rdata <= {4'h0, interrupt_stack_pointer_q};
        `CBRF_IDX_SB:  reg_rdata <= {4'h0, static_base_q};
        `CBRF_IDX_FLG: reg_rdata <= {9'h000, processor_flags_q};
        `CBRF_IDX_ASP: reg_rdata <= {4'h0, active_stack_pointer};
        `CBRF_IDX_DW0_UB:
          reg_rdata <= {12'h000, bank_q[bidx(bank_sel, `CBRF_SLOT_DW0)][15:8]};
        `CBRF_IDX_DW0_LB:
          reg_rdata <= {12'h000, bank_q[bidx(bank_sel, `CBRF_SLOT_DW0)][7:0]};
        `CBRF_IDX_DW1_UB:
          reg_rdata <= {12'h000, bank_q[bidx(bank_sel, `CBRF_SLOT_DW1)][15:8]};
        `CBRF_IDX_DW1_LB:
          reg_rdata <= {12'h000, bank_q[bidx(bank_sel, `CBRF_SLOT_DW1)][7:0]};
        default:       reg_rdata <= {AW{1'b0}}; // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // vector address generation
  // ----------------------------------------------------------------------
  // fixed vectors sit four bytes apart from the fixed base, clamped to the last
  always @(posedge clk)
  begin
    if (rst)
    begin
      vec_addr <= `CBRF_ADDR_RST;
      vec_ack  <= 1'b0;
    end
    else
    begin
      vec_ack <= vec_req;
      if (vec_req)
      begin
        if (vec_fixed)
        begin
          if (vec_num[5:4] != 2'h0 || vec_num[3:0] > `CBRF_FIXED_VLAST)
            vec_addr <= `CBRF_FIXED_VBASE + {14'h0000, `CBRF_FIXED_VLAST, 2'h0};
          else
            vec_addr <= `CBRF_FIXED_VBASE + {14'h0000, vec_num[3:0], 2'h0};
        end
        else
          vec_addr <= vector_table_base_q + {12'h000, vec_num, 2'h0};
      end
    end
  end

endmodule // cbrf_top

//--- shared/cbrf_regs.vh
// cbrf register indices, flag positions, reset values and address constants
`ifndef CBRF_REGS_VH
`define CBRF_REGS_VH

// ----------------------------------------------------------------------
// register port indices
// ----------------------------------------------------------------------
`define CBRF_IDX_DW0      5'h00
`define CBRF_IDX_DW1      5'h01
`define CBRF_IDX_DW2      5'h02
`define CBRF_IDX_DW3      5'h03
`define CBRF_IDX_PW0      5'h04
`define CBRF_IDX_PW1      5'h05
`define CBRF_IDX_FB       5'h06
`define CBRF_IDX_VTB      5'h07
`define CBRF_IDX_PC       5'h08
`define CBRF_IDX_USP      5'h09
`define CBRF_IDX_ISP      5'h0a
`define CBRF_IDX_SB       5'h0b
`define CBRF_IDX_FLG      5'h0c
`define CBRF_IDX_ASP      5'h0d
`define CBRF_IDX_DW0_UB   5'h0e
`define CBRF_IDX_DW0_LB   5'h0f
`define CBRF_IDX_DW1_UB   5'h10
`define CBRF_IDX_DW1_LB   5'h11

// ----------------------------------------------------------------------
// banked slot numbers within one bank
// ----------------------------------------------------------------------
`define CBRF_SLOT_DW0     3'h0
`define CBRF_SLOT_DW1     3'h1
`define CBRF_SLOT_DW2     3'h2
`define CBRF_SLOT_DW3     3'h3
`define CBRF_SLOT_PW0     3'h4
`define CBRF_SLOT_PW1     3'h5
`define CBRF_SLOT_FB      3'h6
`define CBRF_BANK_SLOTS   4'h7

// ----------------------------------------------------------------------
// flag bit positions
// ----------------------------------------------------------------------
`define CBRF_FLG_C        0
`define CBRF_FLG_D        1
`define CBRF_FLG_Z        2
`define CBRF_FLG_S        3
`define CBRF_FLG_B        4
`define CBRF_FLG_O        5
`define CBRF_FLG_I        6
`define CBRF_FLG_U        7

// ----------------------------------------------------------------------
// long write selectors and alu sizes
// ----------------------------------------------------------------------
`define CBRF_LONG_DLO     2'h0
`define CBRF_LONG_DHI     2'h1
`define CBRF_LONG_PTR     2'h2
`define CBRF_SIZE_BYTE    2'h0
`define CBRF_SIZE_WORD    2'h1
`define CBRF_SIZE_LONG    2'h2

// ----------------------------------------------------------------------
// reset values and address constants
// ----------------------------------------------------------------------
`define CBRF_WORD_RST     16'h0000
`define CBRF_ADDR_RST     20'h00000
`define CBRF_FLG_RST      11'h000
`define CBRF_FIXED_VBASE  20'h0ffdc
`define CBRF_FIXED_VLAST  4'h8

`endif

//--- bench/cbrf_alu_model.sv
// cbrf alu model: sized add that reports result, carry and overflow to the flags
`timescale 1ns/10ps
module cbrf_alu_model (
  input  wire        go,
  input  wire [1:0]  alu_size,
  input  wire [31:0] op_a,
  input  wire [31:0] op_b,
  output wire        alu_flag_we,
  output reg  [31:0] alu_result,
  output reg         alu_carry,
  output reg         alu_overflow
);
  reg     [32:0] sum;
  reg     [31:0] mk;
  integer        mb;
  // add at byte, word or long width; size 3 acts as word
  always @*
  begin
    mb = (alu_size == 2'h0) ? 7 : (alu_size == 2'h2) ? 31 : 15;
    mk = (alu_size == 2'h0) ? 32'h000000ff : (alu_size == 2'h2) ? 32'hffffffff : 32'h0000ffff;
    sum = {1'b0, op_a & mk} + {1'b0, op_b & mk};
    alu_result = sum[31:0];
    alu_carry = sum[mb+1];
    alu_overflow = (op_a[mb] == op_b[mb]) && (sum[mb] != op_a[mb]);
  end
  // flag update strobe follows the request
  assign alu_flag_we = go;
endmodule  // cbrf_alu_model

//--- bench/cbrf_chk_sva.sv
// cbrf checker: port-level assertions for the banked register set
`timescale 1ns/10ps
`include "cbrf_regs.vh"
module cbrf_chk #(
  parameter DW = 16,
  parameter AW = 20,
  parameter FW = 11
) (
  input wire          clk,
  input wire          rst,
  input wire [4:0]    reg_addr,
  input wire          reg_wr,
  input wire          long_wr,
  input wire [1:0]    long_sel,
  input wire [31:0]   long_wdata,
  input wire          alu_flag_we,
  input wire [1:0]    alu_size,
  input wire [31:0]   alu_result,
  input wire          alu_carry,
  input wire          alu_overflow,
  input wire          pc_adv,
  input wire [2:0]    pc_step,
  input wire          vec_req,
  input wire          vec_fixed,
  input wire [5:0]    vec_num,
  input wire [AW-1:0] vec_addr,
  input wire          vec_ack,
  input wire [31:0]   long_data_pair_low,
  input wire [31:0]   long_pointer_pair,
  input wire [AW-1:0] program_counter,
  input wire [AW-1:0] vector_table_base,
  input wire [FW-1:0] processor_flags
);
  // --------
  // vector, pc, flag and pair relations
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_fix_req; vec_req && vec_fixed && (vec_num <= 6'h08); endsequence
  sequence s_ack; vec_ack ##1 !vec_ack; endsequence
  property p_vec_fix; s_fix_req |=> vec_addr == 20'h0ffdc + {$past(vec_num), 2'b00}; endproperty
  property p_vec_clamp; vec_req && vec_fixed && vec_num > 6'h08 |=> vec_addr == 20'h0fffc;
  endproperty
  property p_vec_rel; vec_req && !vec_fixed |=>
    vec_addr == $past(vector_table_base) + {$past(vec_num), 2'b00}; endproperty
  property p_vec_pulse; vec_req ##1 !vec_req |-> s_ack; endproperty
  property p_pc_adv; pc_adv && !(reg_wr && reg_addr == `CBRF_IDX_PC) |=>
    program_counter == $past(program_counter) + $past(pc_step); endproperty
  property p_pc_hold; !pc_adv && !reg_wr |=> $stable(program_counter); endproperty
  property p_flg_co; alu_flag_we |=> processor_flags[`CBRF_FLG_C] == $past(alu_carry) &&
    processor_flags[`CBRF_FLG_O] == $past(alu_overflow); endproperty
  property p_flg_z; alu_flag_we && alu_size == `CBRF_SIZE_WORD && alu_result[15:0] == 16'h0000
    |=> processor_flags[`CBRF_FLG_Z] && !processor_flags[`CBRF_FLG_S]; endproperty
  property p_flg_s; alu_flag_we && alu_size == `CBRF_SIZE_WORD && alu_result[15]
    |=> processor_flags[`CBRF_FLG_S] && !processor_flags[`CBRF_FLG_Z]; endproperty
  property p_flg_hold; !alu_flag_we && !reg_wr |=> $stable(processor_flags); endproperty
  property p_long_lo; long_wr && long_sel == `CBRF_LONG_DLO && !reg_wr |=>
    long_data_pair_low == $past(long_wdata); endproperty
  property p_long_ptr; long_wr && long_sel == `CBRF_LONG_PTR && !reg_wr |=>
    long_pointer_pair == $past(long_wdata); endproperty
  a_vec_fix: assert property (p_vec_fix) else $error("fixed vector address wrong");
  a_vec_clamp: assert property (p_vec_clamp) else $error("vector clamp wrong");
  a_vec_rel: assert property (p_vec_rel) else $error("table vector address wrong");
  a_vec_pulse: assert property (p_vec_pulse) else $error("vector ack not a pulse");
  a_pc_adv: assert property (p_pc_adv) else $error("pc advance wrong");
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved while idle");
  a_flg_co: assert property (p_flg_co) else $error("carry or overflow flag wrong");
  a_flg_z: assert property (p_flg_z) else $error("zero flag wrong");
  a_flg_s: assert property (p_flg_s) else $error("sign flag wrong");
  a_flg_hold: assert property (p_flg_hold) else $error("flags moved while idle");
  a_long_lo: assert property (p_long_lo) else $error("data pair write wrong");
  a_long_ptr: assert property (p_long_ptr) else $error("pointer pair write wrong");
endmodule  // cbrf_chk
bind cbrf_top cbrf_chk #(.DW(DW), .AW(AW), .FW(FW)) chk_u (.clk, .rst, .reg_addr, .reg_wr,
  .long_wr, .long_sel, .long_wdata, .alu_flag_we, .alu_size, .alu_result, .alu_carry,
  .alu_overflow, .pc_adv, .pc_step, .vec_req, .vec_fixed, .vec_num, .vec_addr, .vec_ack,
  .long_data_pair_low, .long_pointer_pair, .program_counter, .vector_table_base,
  .processor_flags);

//--- bench/tb_top.sv
// cbrf testbench: register port, pair, bank, stack, flag, pc and vector scenarios
`timescale 1ns/10ps
`include "cbrf_regs.vh"
module tb_top;
  logic        clk, rst, reg_wr, reg_rd, long_wr, pc_adv, vec_req, vec_fixed, go, pend;
  logic [4:0]  reg_addr;
  logic [19:0] reg_wdata;
  logic [1:0]  long_sel, alu_size;
  logic [31:0] long_wdata, op_a, op_b, r, msk;
  logic [2:0]  pc_step;
  logic [5:0]  vec_num;
  wire  [19:0] reg_rdata, vec_addr, program_counter, vector_table_base;
  wire         vec_ack, alu_flag_we, alu_carry, alu_overflow;
  wire  [31:0] alu_result, long_data_pair_low, long_data_pair_high, long_pointer_pair;
  wire  [15:0] frame_base, static_base, active_stack_pointer;
  wire  [10:0] processor_flags;
  logic [19:0] exp_q[$];
  logic [19:0] m[0:12];
  logic [10:0] fl;
  int          n_fail, total_checks, i, n;
  logic [31:0] ta[0:4] = '{32'h80, 32'h7fff, 32'hffffffff, 32'hffff, 32'h1};
  logic [1:0]  ts[0:4] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h3};
  cbrf_top dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .long_wr,
    .long_sel, .long_wdata, .alu_flag_we, .alu_size, .alu_result, .alu_carry, .alu_overflow,
    .pc_adv, .pc_step, .vec_req, .vec_fixed, .vec_num, .vec_addr, .vec_ack, .long_data_pair_low,
    .long_data_pair_high, .long_pointer_pair, .frame_base, .static_base, .active_stack_pointer,
    .program_counter, .vector_table_base, .processor_flags);
  cbrf_alu_model alu_u (.go, .alu_size, .op_a, .op_b, .alu_flag_we, .alu_result, .alu_carry,
    .alu_overflow);
  // --------
  // clock, compare, drivers
  // --------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e)
    begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, e);
    end
  endtask
  // read results are taken off the queue one cycle after the strobe
  always @(negedge clk)
  begin
    if (pend)
      chk(reg_rdata, exp_q.pop_front());
    pend = reg_rd;
  end
  task automatic wr(input logic [4:0] a, input logic [19:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [4:0] a, input logic [19:0] e);
    @(posedge clk);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
  endtask
  task automatic idle;
    @(posedge clk);
    {reg_wr, reg_rd, long_wr, pc_adv, vec_req, go} <= 6'h00;
    #1;
  endtask
  task automatic lw(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    long_wr    <= 1'b1;
    long_sel   <= s;
    long_wdata <= d;
  endtask
  task automatic alu(input logic [1:0] s, input logic [31:0] a);
    @(posedge clk);
    go       <= 1'b1;
    alu_size <= s;
    op_a     <= a;
    op_b     <= (s == 2'h0) ? 32'h80 : 32'h1;
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog against a hung run
  initial
  begin
    #20000;
    n_fail++;
    give_verdict;
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, long_wr, pc_adv, vec_req, vec_fixed, go, pend} = 8'h00;
    {reg_addr, reg_wdata, long_sel, long_wdata, alu_size, op_a, op_b, pc_step, vec_num} = '0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(80785));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 13; i++) rd(5'(i), 20'h00000);
    wr(5'h12, 20'h0ffff);
    rd(5'h12, 20'h00000);
    for (i = 0; i < 12; i++)
    begin
      m[i] = 20'($urandom) & ((i == 7 || i == 8) ? 20'hfffff : 20'h0ffff);
      wr(5'(i), m[i]);
    end
    fl = 11'($urandom) & 11'h76d;
    m[12] = fl;
    wr(5'h0c, fl);
    for (i = 0; i < 13; i++) rd(5'(i), m[i]);
    idle;
    chk(long_data_pair_low, {m[2][15:0], m[0][15:0]});
    chk(long_data_pair_high, {m[3][15:0], m[1][15:0]});
    chk(long_pointer_pair, {m[5][15:0], m[4][15:0]});
    chk(frame_base, m[6]);
    chk(vector_table_base, m[7]);
    chk(program_counter, m[8]);
    chk(static_base, m[11]);
    chk(active_stack_pointer, m[10]);
    chk(processor_flags, fl);
    m[0][15:8] = 8'ha5;
    m[1][7:0] = 8'h5a;
    wr(`CBRF_IDX_DW0_UB, 20'h000a5);
    wr(`CBRF_IDX_DW1_LB, 20'h0005a);
    rd(5'h00, m[0]);
    rd(5'h01, m[1]);
    idle;
    r = $urandom;
    lw(`CBRF_LONG_DLO, r);
    m[2] = r[31:16];
    m[0] = r[15:0];
    r = $urandom;
    lw(`CBRF_LONG_PTR, r);
    lw(2'h3, 32'hffffffff);
    idle;
    chk(long_pointer_pair, r);
    m[5] = r[31:16];
    m[4] = r[15:0];
    for (i = 0; i < 6; i++) rd(5'(i), m[i]);
    wr(5'h0c, fl | 11'h010);
    wr(5'h00, 20'h0beef);
    rd(5'h00, 20'h0beef);
    rd(5'h04, 20'h00000);
    wr(5'h0c, fl);
    rd(5'h00, m[0]);
    m[10] = 20'h01234;
    wr(`CBRF_IDX_ASP, m[10]);
    rd(5'h0a, m[10]);
    fl = fl | 11'h080;
    wr(5'h0c, fl);
    wr(`CBRF_IDX_ASP, 20'h0abcd);
    rd(5'h09, 20'h0abcd);
    rd(5'h0a, m[10]);
    idle;
    chk(active_stack_pointer, 16'habcd);
    for (i = 0; i < 11; i++)
    begin
      alu((i < 5) ? ts[i] : 2'($urandom), (i < 5) ? ta[i] : $urandom);
      idle;
      msk = (alu_size == 2'h0) ? 32'hff : (alu_size == 2'h2) ? 32'hffffffff : 32'hffff;
      fl[`CBRF_FLG_C] = alu_carry;
      fl[`CBRF_FLG_O] = alu_overflow;
      fl[`CBRF_FLG_Z] = (alu_result & msk) == 32'h0;
      fl[`CBRF_FLG_S] = |(alu_result & (msk ^ (msk >> 1)));
      chk(processor_flags, fl);
    end
    wr(`CBRF_IDX_PC, 20'hffffe);
    idle;
    @(posedge clk);
    pc_adv  <= 1'b1;
    pc_step <= 3'h3;
    @(posedge clk);
    pc_step <= 3'h7;
    idle;
    chk(program_counter, 20'h00008);
    for (i = 0; i < 11; i++)
    begin
      n = (i == 9) ? 63 : (i == 10) ? 60 : i;
      @(posedge clk);
      vec_req   <= 1'b1;
      vec_fixed <= (i < 10);
      vec_num   <= 6'(n);
      idle;
      chk(vec_ack, 32'h1);
      chk(vec_addr, (i == 10) ? m[7] + 20'd240 : (i == 9) ? 20'h0fffc : 20'h0ffdc + 4 * n);
    end
    idle;
    idle;
    give_verdict;
  end
endmodule  // tb_top
